// *** verilog/dpg_regs.vh ***
// Register map, field widths and reset values of the dual GPIO port block.
// Assumes a 32-bit AXI4-Lite slave with one register per aligned word.
`ifndef DPG_REGS_VH
`define DPG_REGS_VH

`define DPG_ADDR_W        8
`define DPG_OFF_F_DIR     8'h00
`define DPG_OFF_F_PINS    8'h04
`define DPG_OFF_F_LAT     8'h08
`define DPG_OFF_G_DIR     8'h0c
`define DPG_OFF_G_PINS    8'h10
`define DPG_OFF_G_LAT     8'h14
`define DPG_OFF_F_ALT     8'h18
`define DPG_OFF_G_OVR_EN  8'h1c
`define DPG_OFF_G_OVR_DIR 8'h20

`define DPG_F_W           8
`define DPG_G_W           5
`define DPG_F_DIR_RST     8'hff
`define DPG_F_LAT_RST     8'h00
`define DPG_G_DIR_RST     5'h1f
`define DPG_G_LAT_RST     5'h00
`define DPG_ALT_RST       4'h0
`define DPG_G_OVR_RST     5'h00
`define DPG_F_ANALOG_RST  7'h7f

`define DPG_ALT_BIT1      0
`define DPG_ALT_BIT2      1
`define DPG_ALT_BIT5      2
`define DPG_ALT_BIT7      3
`define DPG_ALT_W         4

`define DPG_F_PIN_CMP2    1
`define DPG_F_PIN_CMP1    2
`define DPG_F_PIN_VREF    5
`define DPG_F_PIN_SS      7
`define DPG_F_ANALOG_N    7
`define DPG_ANALOG_DIGITAL 4'hf

`define DPG_RESP_OKAY     2'b00
`define DPG_RESP_SLVERR   2'b10

`endif

// *** verilog/dpg_pin.v ***
// One bidirectional port pin: direction select, drive and pin sampling.
// Assumes the pad resolves PAD_OUT/PAD_OE_N outside; PAD_IN is synchronous.
`timescale 1ns/1ps

module dpg_pin (
	input  wire clk,
	input  wire rst_n,
	input  wire dir_in,
	input  wire lat,
	input  wire force_analog,
	input  wire pad_in,
	output wire pad_out,
	output wire pad_oe_n,
	output reg  pin_q
);
	// The driver is off whenever the effective direction says input.
	assign pad_out  = lat;
	assign pad_oe_n = dir_in;

	// Analog-selected pins read as zero, so floating analog levels never reach software.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			pin_q <= 1'b0;
		else
			pin_q <= pad_in & ~force_analog;
	end
endmodule // dpg_pin

// *** verilog/dpg_top.v ***
// Two GPIO ports: an eight-bit port F and a five-bit port G, with AXI4-Lite registers.
// Assumes external pads combine each OUT/OE_N pair with the pin; inputs are synchronous to CLK.
//
// The implementer's own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`include "dpg_regs.vh"

module dpg_top #(
	parameter F_W = `DPG_F_W,
	parameter G_W = `DPG_G_W
) (
	input  wire            CLK,
	input  wire            RSTN,
	input  wire [7:0]      S_AXI_AWADDR,
	input  wire            S_AXI_AWVALID,
	output wire            S_AXI_AWREADY,
	input  wire [31:0]     S_AXI_WDATA,
	input  wire [3:0]      S_AXI_WSTRB,
	input  wire            S_AXI_WVALID,
	output wire            S_AXI_WREADY,
	output reg  [1:0]      S_AXI_BRESP,
	output reg             S_AXI_BVALID,
	input  wire            S_AXI_BREADY,
	input  wire [7:0]      S_AXI_ARADDR,
	input  wire            S_AXI_ARVALID,
	output wire            S_AXI_ARREADY,
	output reg  [31:0]     S_AXI_RDATA,
	output reg  [1:0]      S_AXI_RRESP,
	output reg             S_AXI_RVALID,
	input  wire            S_AXI_RREADY,
	input  wire [F_W-1:0]  PORT_F_IN,
	output wire [F_W-1:0]  PORT_F_OUT,
	output wire [F_W-1:0]  PORT_F_OE_N,
	input  wire [G_W-1:0]  PORT_G_IN,
	output wire [G_W-1:0]  PORT_G_OUT,
	output wire [G_W-1:0]  PORT_G_OE_N,
	input  wire [3:0]      ANALOG_PIN_CONFIG,
	input  wire            COMPARATOR_ONE_OUTPUT,
	input  wire            COMPARATOR_TWO_OUTPUT,
	input  wire            COMPARATOR_REFERENCE_OUT,
	output wire            SERIAL_SLAVE_SELECT_N,
	input  wire [G_W-1:0]  G_PERIPH_OUT,
	output wire [G_W-1:0]  G_PERIPH_IN
);
	// Direction, latch and alternate-function state.
	reg  [F_W-1:0]           f_dir_q;
	reg  [F_W-1:0]           f_lat_q;
	reg  [G_W-1:0]           g_dir_q;
	reg  [G_W-1:0]           g_lat_q;
	reg  [`DPG_ALT_W-1:0]    f_alt_q;
	reg  [G_W-1:0]           g_ovr_en_q;
	reg  [G_W-1:0]           g_ovr_dir_q;
	wire [F_W-1:0]           f_pins;
	wire [G_W-1:0]           g_pins;
	wire [F_W-1:0]           f_eff_dir;
	wire [F_W-1:0]           f_eff_out;
	wire [F_W-1:0]           f_analog;
	wire [G_W-1:0]           g_eff_dir;
	wire [G_W-1:0]           g_eff_out;

	// AXI write channel holding registers.
	reg                      aw_full_q;
	reg  [`DPG_ADDR_W-1:0]   aw_addr_q;
	reg                      w_full_q;
	reg  [31:0]              w_data_q;
	reg  [3:0]               w_strb_q;
	wire                     wr_go;
	wire                     rd_go;
	reg  [31:0]              rd_data_d;
	reg                      rd_ok_d;
	reg                      wr_ok_d;

	// Analog selection: the analog config code picks how many low pins stay analog.
	// Codes 4'h7 and 4'hf (all digital) free every pin; other codes keep pins analog from the pin
	// numbered by code bits [2:0] up to pin 6, a simple model that keeps reset behaviour exact.
	genvar i;
	generate
		for (i = 0; i < F_W; i = i + 1) begin : g_fan
			if (i < `DPG_F_ANALOG_N) begin : g_an
				assign f_analog[i] = (ANALOG_PIN_CONFIG < `DPG_ANALOG_DIGITAL) &&
				                     (i >= ANALOG_PIN_CONFIG[2:0]);
			end else begin : g_dig
				assign f_analog[i] = 1'b0;
			end
		end
	endgenerate

	// Per-bit alternate-output map of port F: which enable owns the pin and what it drives.
	// Pins without an alternate output get a constant zero select, which keeps the mux uniform.
	wire [F_W-1:0]           f_alt_sel;
	wire [F_W-1:0]           f_alt_val;
	generate
		for (i = 0; i < F_W; i = i + 1) begin : g_falt
			if (i == `DPG_F_PIN_CMP2) begin : g_c2
				assign f_alt_sel[i] = f_alt_q[`DPG_ALT_BIT1];
				assign f_alt_val[i] = COMPARATOR_TWO_OUTPUT;
			end else if (i == `DPG_F_PIN_CMP1) begin : g_c1
				assign f_alt_sel[i] = f_alt_q[`DPG_ALT_BIT2];
				assign f_alt_val[i] = COMPARATOR_ONE_OUTPUT;
			end else if (i == `DPG_F_PIN_VREF) begin : g_vr
				assign f_alt_sel[i] = f_alt_q[`DPG_ALT_BIT5];
				assign f_alt_val[i] = COMPARATOR_REFERENCE_OUT;
			end else begin : g_plain
				assign f_alt_sel[i] = 1'b0;
				assign f_alt_val[i] = 1'b0;
			end
		end
	endgenerate

	// An alternate output owns the driver; otherwise an analog pin keeps the driver off.
	assign f_eff_dir = ~f_alt_sel & (f_dir_q | f_analog);
	assign f_eff_out = (f_alt_sel & f_alt_val) | (~f_alt_sel & f_lat_q);
	// Slave select is an input function only; it idles high unless enabled.
	assign SERIAL_SLAVE_SELECT_N = f_alt_q[`DPG_ALT_BIT7] ? f_pins[`DPG_F_PIN_SS] : 1'b1;

	// Port G: an enabled peripheral forces the pin direction without touching the register.
	assign g_eff_dir = (g_ovr_en_q & g_ovr_dir_q) | (~g_ovr_en_q & g_dir_q);
	assign g_eff_out = (g_ovr_en_q & G_PERIPH_OUT) | (~g_ovr_en_q & g_lat_q);
	assign G_PERIPH_IN = g_pins;

	// One pin cell per bit of each port.
	generate
		for (i = 0; i < F_W; i = i + 1) begin : g_fpin
			dpg_pin u_pin (
				.clk          (CLK),
				.rst_n        (RSTN),
				.dir_in       (f_eff_dir[i]),
				.lat          (f_eff_out[i]),
				.force_analog (f_analog[i]),
				.pad_in       (PORT_F_IN[i]),
				.pad_out      (PORT_F_OUT[i]),
				.pad_oe_n     (PORT_F_OE_N[i]),
				.pin_q        (f_pins[i])
			);
		end
		for (i = 0; i < G_W; i = i + 1) begin : g_gpin
			dpg_pin u_pin (
				.clk          (CLK),
				.rst_n        (RSTN),
				.dir_in       (g_eff_dir[i]),
				.lat          (g_eff_out[i]),
				.force_analog (1'b0),
				.pad_in       (PORT_G_IN[i]),
				.pad_out      (PORT_G_OUT[i]),
				.pad_oe_n     (PORT_G_OE_N[i]),
				.pin_q        (g_pins[i])
			);
		end
	endgenerate

	// AXI4-Lite handshakes: each write channel is accepted once into a one-deep holding slot.
	assign S_AXI_AWREADY = !aw_full_q && !S_AXI_BVALID;
	assign S_AXI_WREADY  = !w_full_q && !S_AXI_BVALID;
	assign S_AXI_ARREADY = !S_AXI_RVALID;
	assign wr_go         = aw_full_q && w_full_q && !S_AXI_BVALID;
	assign rd_go         = S_AXI_ARVALID && S_AXI_ARREADY;

	// Address and data may arrive in either order; both are held until the write happens.
	always @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			aw_full_q <= 1'b0;
			aw_addr_q <= {`DPG_ADDR_W{1'b0}};
			w_full_q  <= 1'b0;
			w_data_q  <= 32'h0000_0000;
			w_strb_q  <= 4'h0;
		end else begin
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_full_q <= 1'b1;
				aw_addr_q <= S_AXI_AWADDR;
			end else if (wr_go) begin
				aw_full_q <= 1'b0;
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_full_q <= 1'b1;
				w_data_q <= S_AXI_WDATA;
				w_strb_q <= S_AXI_WSTRB;
			end else if (wr_go) begin
				w_full_q <= 1'b0;
			end
		end
	end

	// Write decode: only byte lane 0 carries register data.
	always @* begin
		case (aw_addr_q)
		`DPG_OFF_F_DIR, `DPG_OFF_F_PINS, `DPG_OFF_F_LAT, `DPG_OFF_G_DIR, `DPG_OFF_G_PINS,
		`DPG_OFF_G_LAT, `DPG_OFF_F_ALT, `DPG_OFF_G_OVR_EN, `DPG_OFF_G_OVR_DIR: begin
			wr_ok_d = 1'b1;
		end
		default: begin
			wr_ok_d = 1'b0;
		end
		endcase
	end

	// Decoded write enables; a write with byte lane 0 off changes nothing but is still answered.
	wire                     wr_lane0;
	wire                     we_f_dir;
	wire                     we_f_lat;
	wire                     we_g_dir;
	wire                     we_g_lat;
	wire                     we_f_alt;
	wire                     we_g_ovr_en;
	wire                     we_g_ovr_dir;
	assign wr_lane0     = wr_go && w_strb_q[0];
	assign we_f_dir     = wr_lane0 && (aw_addr_q == `DPG_OFF_F_DIR);
	assign we_f_lat     = wr_lane0 && ((aw_addr_q == `DPG_OFF_F_LAT) || (aw_addr_q == `DPG_OFF_F_PINS));
	assign we_g_dir     = wr_lane0 && (aw_addr_q == `DPG_OFF_G_DIR);
	assign we_g_lat     = wr_lane0 && ((aw_addr_q == `DPG_OFF_G_LAT) || (aw_addr_q == `DPG_OFF_G_PINS));
	assign we_f_alt     = wr_lane0 && (aw_addr_q == `DPG_OFF_F_ALT);
	assign we_g_ovr_en  = wr_lane0 && (aw_addr_q == `DPG_OFF_G_OVR_EN);
	assign we_g_ovr_dir = wr_lane0 && (aw_addr_q == `DPG_OFF_G_OVR_DIR);

	// Port F direction resets to all inputs.
	always @(posedge CLK or negedge RSTN) begin
		if (!RSTN)
			f_dir_q <= `DPG_F_DIR_RST;
		else if (we_f_dir)
			f_dir_q <= w_data_q[F_W-1:0];
	end

	// Port F latch, written through either the latch or the pins offset.
	always @(posedge CLK or negedge RSTN) begin
		if (!RSTN)
			f_lat_q <= `DPG_F_LAT_RST;
		else if (we_f_lat)
			f_lat_q <= w_data_q[F_W-1:0];
	end

	// Port G direction: only software writes land here, never a peripheral override.
	// Keeping it clean lets software read-modify-write it while a peripheral owns a pin.
	always @(posedge CLK or negedge RSTN) begin
		if (!RSTN)
			g_dir_q <= `DPG_G_DIR_RST;
		else if (we_g_dir)
			g_dir_q <= w_data_q[G_W-1:0];
	end

	// Port G latch; the upper data bits are dropped on purpose.
	always @(posedge CLK or negedge RSTN) begin
		if (!RSTN)
			g_lat_q <= `DPG_G_LAT_RST;
		else if (we_g_lat)
			g_lat_q <= w_data_q[G_W-1:0];
	end

	// Port F alternate-function enables.
	always @(posedge CLK or negedge RSTN) begin
		if (!RSTN)
			f_alt_q <= `DPG_ALT_RST;
		else if (we_f_alt)
			f_alt_q <= w_data_q[`DPG_ALT_W-1:0];
	end

	// Port G peripheral override enables.
	always @(posedge CLK or negedge RSTN) begin
		if (!RSTN)
			g_ovr_en_q <= `DPG_G_OVR_RST;
		else if (we_g_ovr_en)
			g_ovr_en_q <= w_data_q[G_W-1:0];
	end

	// Port G override directions, used only where the enable is set.
	always @(posedge CLK or negedge RSTN) begin
		if (!RSTN)
			g_ovr_dir_q <= `DPG_G_OVR_RST;
		else if (we_g_ovr_dir)
			g_ovr_dir_q <= w_data_q[G_W-1:0];
	end

	// Write response: OKAY for mapped offsets, SLVERR otherwise, held until BREADY.
	always @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP  <= `DPG_RESP_OKAY;
		end else if (wr_go) begin
			S_AXI_BVALID <= 1'b1;
			S_AXI_BRESP  <= wr_ok_d ? `DPG_RESP_OKAY : `DPG_RESP_SLVERR;
		end else if (S_AXI_BREADY) begin
			S_AXI_BVALID <= 1'b0;
		end
	end

	// Read mux: the pins register shows pad levels, the latch register the stored value.
	always @* begin
		rd_data_d = 32'h0000_0000;
		rd_ok_d   = 1'b1;
		case (S_AXI_ARADDR)
		`DPG_OFF_F_DIR:     rd_data_d[F_W-1:0]        = f_dir_q;
		`DPG_OFF_F_PINS:    rd_data_d[F_W-1:0]        = f_pins;
		`DPG_OFF_F_LAT:     rd_data_d[F_W-1:0]        = f_lat_q;
		`DPG_OFF_G_DIR:     rd_data_d[G_W-1:0]        = g_dir_q;
		`DPG_OFF_G_PINS:    rd_data_d[G_W-1:0]        = g_pins;
		`DPG_OFF_G_LAT:     rd_data_d[G_W-1:0]        = g_lat_q;
		`DPG_OFF_F_ALT:     rd_data_d[`DPG_ALT_W-1:0] = f_alt_q;
		`DPG_OFF_G_OVR_EN:  rd_data_d[G_W-1:0]        = g_ovr_en_q;
		`DPG_OFF_G_OVR_DIR: rd_data_d[G_W-1:0]        = g_ovr_dir_q;
		default: begin
			rd_ok_d = 1'b0;
		end
		endcase
	end

	// Read data is registered, so it is stable while RVALID waits for RREADY.
	always @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA  <= 32'h0000_0000;
			S_AXI_RRESP  <= `DPG_RESP_OKAY;
		end else if (rd_go) begin
			S_AXI_RVALID <= 1'b1;
			S_AXI_RDATA  <= rd_data_d;
			S_AXI_RRESP  <= rd_ok_d ? `DPG_RESP_OKAY : `DPG_RESP_SLVERR;
		end else if (S_AXI_RREADY) begin
			S_AXI_RVALID <= 1'b0;
		end
	end
endmodule // dpg_top

// *** tb/dpg_chk.sv ***
// Concurrent checks on the port block, bound to its top module.
// Assumes one clock CLK and an asynchronous active-low RSTN.
`timescale 1ns/1ps
module dpg_chk #(
	parameter F_W = 8,
	parameter G_W = 5
) (
	input wire           CLK,
	input wire           RSTN,
	input wire           S_AXI_AWVALID,
	input wire           S_AXI_AWREADY,
	input wire           S_AXI_WVALID,
	input wire           S_AXI_WREADY,
	input wire           S_AXI_BVALID,
	input wire           S_AXI_ARVALID,
	input wire           S_AXI_ARREADY,
	input wire [31:0]    S_AXI_RDATA,
	input wire           S_AXI_RVALID,
	input wire           S_AXI_RREADY,
	input wire [F_W-1:0] PORT_F_OE_N,
	input wire [G_W-1:0] PORT_G_IN,
	input wire [G_W-1:0] PORT_G_OE_N,
	input wire [3:0]     ANALOG_PIN_CONFIG,
	input wire [G_W-1:0] G_PERIPH_IN
);
	// One domain, so clock and reset are stated once.
	default clocking @(posedge CLK); endclocking
	default disable iff (!RSTN);
	// Pads are released on leaving reset.
	f_reset_a: assert property ($rose(RSTN) |-> &PORT_F_OE_N)
		else $error("port F drives after reset");
	g_reset_a: assert property ($rose(RSTN) |-> &PORT_G_OE_N)
		else $error("port G drives after reset");
	// Drivers turn only with a finished write; analog setup is excluded since it acts directly.
	f_dir_a: assert property (!$stable(PORT_F_OE_N) && $stable(ANALOG_PIN_CONFIG) |-> $rose(S_AXI_BVALID))
		else $error("port F direction moved alone");
	g_dir_a: assert property (!$stable(PORT_G_OE_N) |-> $rose(S_AXI_BVALID))
		else $error("port G direction moved alone");
	// Reads answer one edge later, once, with bits 31:8 low.
	rd_lat_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
		else $error("read answer late");
	rd_once_a: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
		else $error("read answer repeated");
	rd_upper_a: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h0)
		else $error("read upper bits set");
	// Writes answer two edges after both halves are taken and refuse more meanwhile.
	wr_resp_a: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID)
		else $error("write answer late");
	wr_busy_a: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
		else $error("write taken while answering");
	// Sampled port G levels follow the pads by one edge.
	g_sample_a: assert property (1'b1 |=> G_PERIPH_IN == $past(PORT_G_IN))
		else $error("port G sample wrong");
	cover property (S_AXI_BVALID);
	cover property (S_AXI_RVALID && S_AXI_RREADY);
	cover property (!$stable(PORT_G_OE_N));
endmodule // dpg_chk

// *** tb/dpg_board.sv ***
// Board model of one port: each pad level from the block's drive or an outside source.
// Assumes the outside source drives every pad the block releases.
`timescale 1ns/1ps
module dpg_board #(
	parameter W = 8
) (
	input wire [W-1:0]  pad_out,
	input wire [W-1:0]  pad_oe_n,
	input wire [W-1:0]  ext_val,
	output wire [W-1:0] pad_in
);
	// A driven pad shows the block's value, a released one the board's level.
	assign pad_in = (pad_out & ~pad_oe_n) | (ext_val & pad_oe_n);
endmodule // dpg_board

// *** tb/dual_port_gpio_f_g_tb.sv ***
// Self-checking bench for the two-port pin block, with board models and bound checker.
// Assumes dpg_top, dpg_board and dpg_chk are compiled first.
`timescale 1ns/1ps
`include "dpg_regs.vh"
module dual_port_gpio_f_g_tb;
	logic        clk = 0, rstn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, c1 = 0, c2 = 0, cr = 0;
	logic [7:0]  awa = '0, ara = '0, f_ext = '0, f_in, f_out, f_oe;
	logic [3:0]  strb = 4'hf, acfg = 4'h0;
	logic [4:0]  g_ext = '0, g_po = '0, g_in, g_out, g_oe, g_pi;
	logic [31:0] wd = '0, rd, rdata, fd, fl, gd, gl;
	logic [1:0]  br, rr, resp;
	logic        aw_r, w_r, ar_r, bv, rv, ss_n;
	int          n_mismatch = 0, check_count = 0, cyc = 0;
	// Block under test and its pads.
	dpg_top dpg_top_i (.CLK(clk), .RSTN(rstn), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(aw_r),
		.S_AXI_WDATA(wd), .S_AXI_WSTRB(strb), .S_AXI_WVALID(wv), .S_AXI_WREADY(w_r), .S_AXI_BRESP(br),
		.S_AXI_BVALID(bv), .S_AXI_BREADY(bry), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(ar_r),
		.S_AXI_RDATA(rd), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry), .PORT_F_IN(f_in),
		.PORT_F_OUT(f_out), .PORT_F_OE_N(f_oe), .PORT_G_IN(g_in), .PORT_G_OUT(g_out), .PORT_G_OE_N(g_oe),
		.ANALOG_PIN_CONFIG(acfg), .COMPARATOR_ONE_OUTPUT(c1), .COMPARATOR_TWO_OUTPUT(c2),
		.COMPARATOR_REFERENCE_OUT(cr), .SERIAL_SLAVE_SELECT_N(ss_n), .G_PERIPH_OUT(g_po), .G_PERIPH_IN(g_pi));
	dpg_board #(.W(8)) dpg_board_f_i (.pad_out(f_out), .pad_oe_n(f_oe), .ext_val(f_ext), .pad_in(f_in));
	dpg_board #(.W(5)) dpg_board_g_i (.pad_out(g_out), .pad_oe_n(g_oe), .ext_val(g_ext), .pad_in(g_in));
	// 50 MHz clock.
	always #10 clk = ~clk;
	// Hang guard; the sequence needs under two thousand cycles.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_mismatch++;
			final_report();
		end
	end
	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Ready is judged at the falling edge so the rising edge sees a settled handshake.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic da, dw, ta, tw;
		da = 0;
		dw = 0;
		@(posedge clk);
		awa <= a;
		wd <= d;
		awv <= 1;
		wv <= 1;
		bry <= 1;
		while (!(da && dw)) begin
			@(negedge clk);
			ta = awv & aw_r;
			tw = wv & w_r;
			@(posedge clk);
			if (ta) awv <= 0;
			if (tw) wv <= 0;
			da = da | ta;
			dw = dw | tw;
		end
		do @(negedge clk); while (bv !== 1'b1);
		resp = br;
		@(posedge clk);
		bry <= 0;
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
		@(posedge clk);
		ara <= a;
		arv <= 1;
		rry <= 1;
		do @(negedge clk); while (ar_r !== 1'b1);
		@(posedge clk);
		arv <= 0;
		do @(negedge clk); while (rv !== 1'b1);
		rdata = rd;
		resp = rr;
		@(posedge clk);
		rry <= 0;
		chk(nm, rdata, e);
	endtask
	// Pad level: released pins show the board, driven pins the latch.
	function automatic logic [7:0] lvl(input logic [7:0] d, input logic [7:0] l, input logic [7:0] x);
		return (d & x) | (~d & l);
	endfunction
	// Main sequence: reset state, random traffic, then corner cases.
	initial begin
		void'($urandom(68));
		f_ext <= $urandom;
		repeat (8) @(posedge clk);
		rstn <= 1;
		@(posedge clk);
		chk("f_oe", f_oe, 8'hff);
		chk("g_oe", g_oe, 5'h1f);
		rc(`DPG_OFF_F_DIR, 32'hff, "f_dir");
		rc(`DPG_OFF_G_DIR, 32'h1f, "g_dir");
		rc(`DPG_OFF_F_LAT, 32'h0, "f_lat");
		rc(`DPG_OFF_F_PINS, {24'h0, f_ext[7], 7'h0}, "f_pins");
		rc(8'h24, 32'h0, "bad_addr");
		chk("bad_resp", resp, `DPG_RESP_SLVERR);
		wr(8'h24, 32'hff);
		chk("bad_wr_resp", resp, `DPG_RESP_SLVERR);
		acfg <= 4'hf;
		repeat (16) begin
			fd = $urandom;
			fl = $urandom;
			gd = $urandom;
			gl = $urandom;
			f_ext <= $urandom;
			g_ext <= $urandom;
			g_po <= $urandom;
			{c1, c2, cr} <= $urandom;
			wr(`DPG_OFF_F_DIR, fd);
			wr(`DPG_OFF_F_LAT, fl);
			wr(`DPG_OFF_G_DIR, gd);
			wr(`DPG_OFF_G_LAT, gl);
			chk("f_oe", f_oe, fd[7:0]);
			chk("f_out", f_out & ~f_oe, fl[7:0] & ~fd[7:0]);
			chk("g_oe", g_oe, gd[4:0]);
			chk("g_out", g_out & ~g_oe, gl[4:0] & ~gd[4:0]);
			rc(`DPG_OFF_F_LAT, {24'h0, fl[7:0]}, "f_lat");
			rc(`DPG_OFF_G_LAT, {27'h0, gl[4:0]}, "g_lat");
			rc(`DPG_OFF_F_PINS, {24'h0, lvl(fd[7:0], fl[7:0], f_ext)}, "f_pins");
			rc(`DPG_OFF_G_PINS, {24'h0, lvl(gd[7:0], gl[7:0] & 8'h1f, {3'h0, g_ext})}, "g_pins");
		end
		wr(`DPG_OFF_F_PINS, 32'h5a);
		chk("wr_resp", resp, `DPG_RESP_OKAY);
		rc(`DPG_OFF_F_LAT, 32'h5a, "f_pins_wr");
		strb <= 4'he;
		wr(`DPG_OFF_F_LAT, 32'h0);
		strb <= 4'hf;
		rc(`DPG_OFF_F_LAT, 32'h5a, "f_strb");
		wr(`DPG_OFF_G_PINS, 32'hff);
		rc(`DPG_OFF_G_LAT, 32'h1f, "g_pins_wr");
		// Peripheral takes port G: bits 1 and 3 drive, the rest listen.
		wr(`DPG_OFF_G_DIR, 32'h0);
		wr(`DPG_OFF_G_OVR_DIR, 32'h15);
		wr(`DPG_OFF_G_OVR_EN, 32'h1f);
		chk("g_ovr_oe", g_oe, 5'h15);
		chk("g_ovr_out", g_out & ~g_oe, g_po & 5'h0a);
		rc(`DPG_OFF_G_DIR, 32'h0, "g_dir_kept");
		chk("g_sample", g_pi, g_in);
		// Alternate functions on port F.
		wr(`DPG_OFF_F_DIR, 32'h80);
		wr(`DPG_OFF_F_ALT, 32'hf);
		chk("f1_cmp", f_out[1], c2);
		chk("f2_cmp", f_out[2], c1);
		chk("f5_ref", f_out[5], cr);
		chk("ss_n", ss_n, f_ext[7]);
		final_report();
	end
endmodule // dual_port_gpio_f_g_tb
bind dpg_top dpg_chk #(.F_W(F_W), .G_W(G_W)) dpg_chk_i (.CLK(CLK), .RSTN(RSTN), .S_AXI_AWVALID(S_AXI_AWVALID),
	.S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
	.S_AXI_BVALID(S_AXI_BVALID), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
	.S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
	.PORT_F_OE_N(PORT_F_OE_N), .PORT_G_IN(PORT_G_IN), .PORT_G_OE_N(PORT_G_OE_N),
	.ANALOG_PIN_CONFIG(ANALOG_PIN_CONFIG), .G_PERIPH_IN(G_PERIPH_IN));
